//--- logic/usb_tx_ep_cfg.svh
// Offsets, field positions, reset values and timing figures of the TX endpoint block
`ifndef USB_TX_EP_CFG_SVH
`define USB_TX_EP_CFG_SVH
// Register byte offsets
`define EP_CTRL_OFF 8'h00
`define INFO_OFF 8'h04
`define OTG_OFF 8'h08
// Endpoint control field positions
`define B_AUTO 31
`define B_ISO 30
`define B_DIR 29
`define B_DMA_EN 28
`define B_FORCE 27
`define B_DMA_MD 26
`define B_WEN 25
`define B_TGL 24
`define B_ARMED 16
`define F_MAXP 10:0
// Information register fields and reset values
`define F_VBUS_PULSE_LENGTH 31:24
`define F_CONNECT_FILTER_WAIT 23:20
`define F_ID_VALID_DELAY 19:16
`define VBUS_PULSE_LENGTH_RST 8'h3C
`define CONNECT_FILTER_WAIT_RST 4'h5
`define ID_VALID_DELAY_RST 4'hC
`define DMA_CHANS 4'h8
`define RAM_BITS 4'hC
`define RX_EPS 4'h7
`define TX_EPS 4'h7
// Own control/status register bits
`define B_VBUS_GO 0
`define B_PULLUP 1
`define B_VBUS_ON 8
`define B_CONN 9
`define B_ID_VALID 10
`define B_ID_LEVEL 11
`define B_HOST 12
// Times in tenths of a nanosecond
`define CLK_PER_DNS 250
`define VBUS_UNIT_DNS 5461000
`define CONN_UNIT_DNS 5333
`define ID_UNIT_DNS 43690000
`endif

//--- logic/usb_tx_ep_pkg.sv
// Types shared by the TX endpoint block
package usb_tx_ep_pkg;
  typedef enum logic [1:0] {
    ARM_FILL = 2'b01,
    ARM_READY = 2'b10
  } arm_state_type;
  typedef logic [31:0] word_type;
endpackage

//--- logic/usb_tx_ep.sv
// TX endpoint control, OTG delay timers, info register and TX FIFO
// Operation
// - Auto-arm marks packet ready once a full max-size packet is loaded.
// - Device role: iso bit selects isochronous, else bulk/interrupt.
// - Host role: iso bit has no effect and reads zero.
// - Direction bit: 1 transmit, 0 receive, for shared FIFOs.
// - DMA requests only while DMA request enable is set.
// - Force toggle flips data toggle and drops the FIFO packet.
// - DMA mode bit selects request mode 1 or mode 0.
// - Host role: toggle write enable lets software overwrite toggle.
// - Reading toggle bit returns the present data toggle.
// - Toggle writes load only while toggle write enable is set.
// - 8-bit field sets VBUS pulse length in 546.1 us steps.
// - 4-bit field sets connect filter wait in 533.3 ns steps; the logic rounds each step up to 22 clocks (550 ns).
// - 4-bit field sets ID valid delay in 4.369 ms steps.
// - Read-only field reports eight DMA channels.
// - Read-only field reports FIFO RAM address width twelve.
// - Read-only fields report seven RX and seven TX endpoints.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "usb_tx_ep_cfg.svh"

// ------------------------------------------------
// Word FIFO
// ------------------------------------------------
module tx_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = DEPTH[AW:0];
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_r[rd_ptr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      // Flags kept as flops so both handshakes are glitch free
      in_ready <= (cnt_nxt != DEPTH_C);
      out_valid <= (cnt_nxt != '0);
    end
  end
endmodule // tx_word_fifo

// ------------------------------------------------
// Top
// ------------------------------------------------
module usb_tx_ep #(
  parameter int ADDR_W = 8,
  parameter int FIFO_DEPTH = 8,
  parameter int VBUS_UNIT_CYC = `VBUS_UNIT_DNS / `CLK_PER_DNS,
  parameter int ID_UNIT_CYC = `ID_UNIT_DNS / `CLK_PER_DNS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire usb_tx_ep_pkg::word_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output usb_tx_ep_pkg::word_type reg_rdata,
  input wire logic host_mode,
  input wire usb_tx_ep_pkg::word_type tx_in_data,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  output usb_tx_ep_pkg::word_type tx_out_data,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  input wire logic tx_ack,
  output logic tx_packet_armed,
  output logic tx_data_toggle,
  output logic iso_mode,
  output logic endpoint_is_tx,
  output logic dma_req,
  output logic dma_mode,
  output logic vbus_charge,
  input wire logic conn_raw,
  output logic conn_state,
  output logic id_pullup,
  output logic id_valid,
  input wire logic id_pin_level
);
  import usb_tx_ep_pkg::*;

  localparam int CONN_UNIT_CYC =
    (`CONN_UNIT_DNS + `CLK_PER_DNS - 1) / `CLK_PER_DNS;
  localparam int PRE_W = 18;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // ------------------------------------------------
  // Reset release
  // ------------------------------------------------
  logic rst_q1, rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ------------------------------------------------
  // Register writes
  // ------------------------------------------------
  logic wr_ctrl, wr_info, wr_otg;
  logic auto_arm_enable_r, iso_sel_r, dir_r, dma_request_enable_r;
  logic force_toggle_r, dma_request_mode_sel_r, toggle_write_enable_r;
  logic [10:0] tx_max_packet_size_r;
  logic [7:0] vbus_pulse_length_r;
  logic [3:0] connect_filter_wait_r, id_valid_delay_r;
  logic id_pullup_q, vbus_go;

  assign wr_ctrl = reg_wr & hit(reg_addr, `EP_CTRL_OFF);
  assign wr_info = reg_wr & hit(reg_addr, `INFO_OFF);
  assign wr_otg = reg_wr & hit(reg_addr, `OTG_OFF);
  assign vbus_go = wr_otg & reg_wdata[`B_VBUS_GO];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_arm_enable_r <= 1'b0;
      iso_sel_r <= 1'b0;
      dir_r <= 1'b0;
      dma_request_enable_r <= 1'b0;
      dma_request_mode_sel_r <= 1'b0;
      toggle_write_enable_r <= 1'b0;
      tx_max_packet_size_r <= '0;
    end else if (wr_ctrl) begin
      auto_arm_enable_r <= reg_wdata[`B_AUTO];
      iso_sel_r <= reg_wdata[`B_ISO];
      dir_r <= reg_wdata[`B_DIR];
      dma_request_enable_r <= reg_wdata[`B_DMA_EN];
      // Mode is only safe to clear after enable is already low
      dma_request_mode_sel_r <= reg_wdata[`B_DMA_MD];
      toggle_write_enable_r <= reg_wdata[`B_WEN];
      tx_max_packet_size_r <= reg_wdata[`F_MAXP];
    end
  end

  // One-shot: reads back set only in the cycle it acts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      force_toggle_r <= 1'b0;
    end else begin
      force_toggle_r <= wr_ctrl & reg_wdata[`B_FORCE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbus_pulse_length_r <= `VBUS_PULSE_LENGTH_RST;
      connect_filter_wait_r <= `CONNECT_FILTER_WAIT_RST;
      id_valid_delay_r <= `ID_VALID_DELAY_RST;
    end else if (wr_info) begin
      vbus_pulse_length_r <= reg_wdata[`F_VBUS_PULSE_LENGTH];
      connect_filter_wait_r <= reg_wdata[`F_CONNECT_FILTER_WAIT];
      id_valid_delay_r <= reg_wdata[`F_ID_VALID_DELAY];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_pullup <= 1'b0;
      id_pullup_q <= 1'b0;
    end else begin
      if (wr_otg) begin
        id_pullup <= reg_wdata[`B_PULLUP];
      end
      id_pullup_q <= id_pullup;
    end
  end

  // ------------------------------------------------
  // Data path and packet arming
  // ------------------------------------------------
  word_type fifo_data;
  logic fifo_valid, fifo_take, push, arm_set, arm_clr, auto_hit;
  logic [10:0] word_cnt_r;
  arm_state_type arm_r;

  assign push = tx_in_valid & tx_in_ready;
  assign fifo_take = fifo_valid & arm_r[1] & ~force_toggle_r &
                     (~tx_out_valid | tx_out_ready);
  assign auto_hit = auto_arm_enable_r & push & (tx_max_packet_size_r != '0) &
                    (word_cnt_r + 11'h001 == tx_max_packet_size_r);
  // Short packets still need the software arm bit
  assign arm_set = auto_hit | (wr_ctrl & reg_wdata[`B_ARMED]);
  assign arm_clr = tx_ack | force_toggle_r;

  tx_word_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(force_toggle_r),
    .in_data(tx_in_data),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_cnt_r <= '0;
    end else if (force_toggle_r || arm_set) begin
      word_cnt_r <= '0;
    end else if (push) begin
      word_cnt_r <= word_cnt_r + 11'h001;
    end
  end

  // Arming wins over a same-cycle ack so no packet is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_r <= ARM_FILL;
    end else begin
      unique case (arm_r)
        ARM_FILL: begin
          if (arm_set) begin
            arm_r <= ARM_READY;
          end
        end
        ARM_READY: begin
          if (arm_clr && !arm_set) begin
            arm_r <= ARM_FILL;
          end
        end
        default: arm_r <= ARM_FILL;
      endcase
    end
  end
  assign tx_packet_armed = arm_r[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_valid <= 1'b0;
      tx_out_data <= '0;
    end else if (force_toggle_r) begin
      tx_out_valid <= 1'b0;
    end else if (fifo_take) begin
      tx_out_valid <= 1'b1;
      tx_out_data <= fifo_data;
    end else if (tx_out_ready) begin
      tx_out_valid <= 1'b0;
    end
  end

  // ------------------------------------------------
  // Data toggle
  // ------------------------------------------------
  logic tgl_flip, tgl_load;
  assign tgl_flip = tx_ack | force_toggle_r;
  assign tgl_load = wr_ctrl & host_mode & toggle_write_enable_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_toggle <= 1'b0;
    end else if (tgl_flip) begin
      tx_data_toggle <= ~tx_data_toggle;
    end else if (tgl_load) begin
      tx_data_toggle <= reg_wdata[`B_TGL];
    end
  end

  // ------------------------------------------------
  // Mode and DMA outputs
  // ------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iso_mode <= 1'b0;
      endpoint_is_tx <= 1'b0;
      dma_req <= 1'b0;
      dma_mode <= 1'b0;
    end else begin
      iso_mode <= iso_sel_r & ~host_mode;
      endpoint_is_tx <= dir_r;
      dma_mode <= dma_request_mode_sel_r;
      // Mode 1 asks only between packets, mode 0 whenever there is room
      dma_req <= dma_request_enable_r & tx_in_ready &
                 (~dma_request_mode_sel_r | ~arm_r[1]);
    end
  end

  // ------------------------------------------------
  // Delay timers: 0 VBUS pulse, 1 connect filter, 2 ID valid
  // ------------------------------------------------
  localparam int UNIT [3] = '{VBUS_UNIT_CYC, CONN_UNIT_CYC, ID_UNIT_CYC};
  logic [7:0] t_len [3];
  logic [2:0] t_start, t_stop, t_run_r, t_done_r;

  assign t_len[0] = vbus_pulse_length_r;
  assign t_len[1] = {4'h0, connect_filter_wait_r};
  assign t_len[2] = {4'h0, id_valid_delay_r};
  assign t_start[0] = vbus_go;
  assign t_stop[0] = 1'b0;
  assign t_start[1] = (conn_raw != conn_state) & ~t_run_r[1] & ~t_done_r[1];
  assign t_stop[1] = (conn_raw == conn_state);
  assign t_start[2] = id_pullup & ~id_pullup_q;
  assign t_stop[2] = ~id_pullup;

  for (genvar i = 0; i < 3; i++) begin : g_tmr
    logic [PRE_W-1:0] pre_r;
    logic [7:0] step_r;
    logic last;
    // One step per unit of prescaled clock
    assign last = (t_len[i] == '0) ||
                  ((pre_r == PRE_W'(UNIT[i] - 1)) &&
                   (step_r + 8'h01 == t_len[i]));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pre_r <= '0;
        step_r <= '0;
        t_run_r[i] <= 1'b0;
        t_done_r[i] <= 1'b0;
      end else begin
        t_done_r[i] <= 1'b0;
        if (t_start[i]) begin
          pre_r <= '0;
          step_r <= '0;
          t_run_r[i] <= 1'b1;
        end else if (t_stop[i]) begin
          t_run_r[i] <= 1'b0;
        end else if (t_run_r[i]) begin
          if (last) begin
            t_run_r[i] <= 1'b0;
            t_done_r[i] <= 1'b1;
          end else if (pre_r == PRE_W'(UNIT[i] - 1)) begin
            pre_r <= '0;
            step_r <= step_r + 8'h01;
          end else begin
            pre_r <= pre_r + 1'b1;
          end
        end
      end
    end
  end

  assign vbus_charge = t_run_r[0];

  logic id_level_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conn_state <= 1'b0;
      id_valid <= 1'b0;
      id_level_r <= 1'b0;
    end else begin
      if (t_done_r[1] && conn_raw != conn_state) begin
        conn_state <= conn_raw;
      end
      if (!id_pullup) begin
        id_valid <= 1'b0;
      end else if (t_done_r[2]) begin
        id_valid <= 1'b1;
      end
      if (id_valid) begin
        id_level_r <= id_pin_level;
      end
    end
  end

  // ------------------------------------------------
  // Register reads
  // ------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd && hit(reg_addr, `EP_CTRL_OFF)) begin
        reg_rdata[`B_AUTO] <= auto_arm_enable_r;
        reg_rdata[`B_ISO] <= iso_sel_r & ~host_mode;
        reg_rdata[`B_DIR] <= dir_r;
        reg_rdata[`B_DMA_EN] <= dma_request_enable_r;
        reg_rdata[`B_FORCE] <= force_toggle_r;
        reg_rdata[`B_DMA_MD] <= dma_request_mode_sel_r;
        reg_rdata[`B_WEN] <= toggle_write_enable_r;
        reg_rdata[`B_TGL] <= tx_data_toggle;
        reg_rdata[`B_ARMED] <= arm_r[1];
        reg_rdata[`F_MAXP] <= tx_max_packet_size_r;
      end else if (reg_rd && hit(reg_addr, `INFO_OFF)) begin
        reg_rdata <= {vbus_pulse_length_r, connect_filter_wait_r,
                      id_valid_delay_r, `DMA_CHANS, `RAM_BITS,
                      `RX_EPS, `TX_EPS};
      end else if (reg_rd && hit(reg_addr, `OTG_OFF)) begin
        reg_rdata[`B_PULLUP] <= id_pullup;
        reg_rdata[`B_VBUS_ON] <= t_run_r[0];
        reg_rdata[`B_CONN] <= conn_state;
        reg_rdata[`B_ID_VALID] <= id_valid;
        reg_rdata[`B_ID_LEVEL] <= id_level_r;
        reg_rdata[`B_HOST] <= host_mode;
      end
    end
  end

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_auto_arm_sets: assert property (auto_hit |=> tx_packet_armed)
    else $error("auto arm missed");
  a_iso_host_zero: assert property (host_mode |=> !iso_mode)
    else $error("iso active in host role");
  a_iso_device_sel: assert property (
    !host_mode && iso_sel_r |=> iso_mode)
    else $error("iso not applied in device role");
  a_dir_follows: assert property (##1 endpoint_is_tx == $past(dir_r))
    else $error("direction mismatch");
  a_dma_gated: assert property (!dma_request_enable_r |=> !dma_req)
    else $error("dma request while disabled");
  a_dma_mode_sel: assert property (
    ##1 dma_mode == $past(dma_request_mode_sel_r))
    else $error("dma mode mismatch");

  // Only a clean force: no flip or software load in the same window
  sequence s_force;
    wr_ctrl && reg_wdata[`B_FORCE] && !tgl_flip && !tgl_load;
  endsequence
  a_force_flush: assert property (
    s_force ##1 !tx_ack |=> tx_data_toggle != $past(tx_data_toggle, 2)
    && !tx_out_valid)
    else $error("force toggle did not flip or flush");
  a_toggle_lock: assert property (
    wr_ctrl && !toggle_write_enable_r && !tgl_flip
    |=> $stable(tx_data_toggle))
    else $error("toggle written while locked");
  a_info_fixed: assert property (
    reg_rd && hit(reg_addr, `INFO_OFF)
    |=> reg_rdata[15:0] == 16'h8C77)
    else $error("info build fields wrong");

  // Pulse length counted in helper logic, far too long for a delay range
  logic [23:0] vbus_hi_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbus_hi_cnt_r <= '0;
    end else if (vbus_go) begin
      vbus_hi_cnt_r <= '0;
    end else if (vbus_charge) begin
      vbus_hi_cnt_r <= vbus_hi_cnt_r + 24'h000001;
    end
  end

  sequence s_vbus_end;
    $fell(vbus_charge);
  endsequence
  a_vbus_length: assert property (
    s_vbus_end |-> vbus_hi_cnt_r == ((vbus_pulse_length_r == 8'h00) ?
    24'h000001 : 24'(vbus_pulse_length_r * VBUS_UNIT_CYC)))
    else $error("vbus pulse length wrong");
endmodule // usb_tx_ep

//--- sim/usb_peer_model.sv
// Behavioural USB peer that takes TX words and acknowledges whole packets
`timescale 1ns/10ps

module usb_peer_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire usb_tx_ep_pkg::word_type tx_out_data,
  input wire logic tx_out_valid,
  output logic tx_out_ready,
  output logic tx_ack,
  input wire logic stall,
  input wire logic [7:0] ack_len,
  output logic [7:0] rx_cnt,
  output usb_tx_ep_pkg::word_type rx_last
);
  import usb_tx_ep_pkg::*;

  logic [7:0] pkt_cnt_r;

  // Ready is a flop, so a stall takes hold one cycle after it is asked for
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_out_ready <= 1'b0;
      tx_ack <= 1'b0;
      rx_cnt <= 8'h00;
      rx_last <= 32'h0;
      pkt_cnt_r <= 8'h00;
    end else begin
      tx_out_ready <= !stall;
      tx_ack <= 1'b0;
      if (tx_out_valid && tx_out_ready) begin
        rx_cnt <= rx_cnt + 8'h01;
        rx_last <= tx_out_data;
        // Ack only once a whole packet has arrived
        if (pkt_cnt_r + 8'h01 == ack_len) begin
          tx_ack <= 1'b1;
          pkt_cnt_r <= 8'h00;
        end else begin
          pkt_cnt_r <= pkt_cnt_r + 8'h01;
        end
      end
    end
  end
endmodule // usb_peer_model

//--- sim/tb_usb_tx_ep.sv
// Self-checking bench for the TX endpoint block
`timescale 1ns/10ps
`include "usb_tx_ep_cfg.svh"

module tb_usb_tx_ep;
  import usb_tx_ep_pkg::*;

  // ------------------------------------------------
  // Bench plumbing
  // ------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  word_type reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic host_mode = 1'b0;
  word_type tx_in_data = 32'h0;
  logic tx_in_valid = 1'b0;
  logic conn_raw = 1'b0;
  logic id_pin_level = 1'b0;
  logic stall = 1'b0;
  logic [7:0] ack_len = 8'h04;
  logic tgl_exp = 1'b0;
  word_type reg_rdata, tx_out_data, rx_last;
  logic tx_in_ready, tx_out_valid, tx_out_ready, tx_ack, tx_packet_armed, tx_data_toggle;
  logic iso_mode, endpoint_is_tx, dma_req, dma_mode, vbus_charge, conn_state;
  logic id_pullup, id_valid;
  logic [7:0] rx_cnt;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  usb_tx_ep #(.ADDR_W(8), .FIFO_DEPTH(8), .VBUS_UNIT_CYC(4), .ID_UNIT_CYC(6)) i_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_mode(host_mode),
    .tx_in_data(tx_in_data), .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .tx_ack(tx_ack), .tx_packet_armed(tx_packet_armed), .tx_data_toggle(tx_data_toggle),
    .iso_mode(iso_mode), .endpoint_is_tx(endpoint_is_tx), .dma_req(dma_req),
    .dma_mode(dma_mode), .vbus_charge(vbus_charge), .conn_raw(conn_raw),
    .conn_state(conn_state), .id_pullup(id_pullup), .id_valid(id_valid),
    .id_pin_level(id_pin_level));

  usb_peer_model i_peer (
    .clk(clk), .reset_n(reset_n), .tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .tx_ack(tx_ack), .stall(stall), .ack_len(ack_len),
    .rx_cnt(rx_cnt), .rx_last(rx_last));

  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Run is about 420 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input word_type seen, input word_type exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ------------------------------------------------
  // Bus and stream tasks
  // ------------------------------------------------
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_write(input logic [7:0] a, input word_type d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output word_type d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic push_words(input int n, input word_type base);
    for (int i = 0; i < n; i++) begin
      tx_in_valid <= 1'b1;
      tx_in_data <= base + i;
      do @(posedge clk); while (tx_in_ready !== 1'b1);
    end
    tx_in_valid <= 1'b0;
  endtask

  task automatic wait_rx(input logic [7:0] target);
    for (int i = 0; i < 60 && rx_cnt !== target; i++) @(posedge clk);
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_info();
    word_type d;
    reg_read(`INFO_OFF, d);
    check(d, 32'h3C5C_8C77);
    reg_write(`INFO_OFF, 32'h0000_0000);
    reg_read(`INFO_OFF, d);
    check(d, 32'h0000_8C77);
    reg_read(8'h0C, d);
    check(d, 32'h0);
    reg_write(`INFO_OFF, 32'h3C5C_0000);
  endtask

  task automatic t_modes();
    word_type d;
    reg_write(`EP_CTRL_OFF, 32'h6000_0000);
    wait_cycles(2);
    check(iso_mode, 32'h1);
    check(endpoint_is_tx, 32'h1);
    reg_read(`EP_CTRL_OFF, d);
    check(d[30], 32'h1);
    host_mode <= 1'b1;
    wait_cycles(2);
    check(iso_mode, 32'h0);
    reg_read(`EP_CTRL_OFF, d);
    check(d[30], 32'h0);
    reg_write(`EP_CTRL_OFF, 32'h0);
    wait_cycles(2);
    check(endpoint_is_tx, 32'h0);
    host_mode <= 1'b0;
  endtask

  task automatic t_dma();
    reg_write(`EP_CTRL_OFF, 32'h1000_0000);
    wait_cycles(3);
    check(dma_req, 32'h1);
    check(dma_mode, 32'h0);
    reg_write(`EP_CTRL_OFF, 32'h1400_0000);
    wait_cycles(3);
    check(dma_mode, 32'h1);
    check(dma_req, 32'h1);
    reg_write(`EP_CTRL_OFF, 32'h0400_0000);
    wait_cycles(3);
    check(dma_req, 32'h0);
    reg_write(`EP_CTRL_OFF, 32'h0);
  endtask

  task automatic t_toggle();
    word_type d;
    host_mode <= 1'b1;
    reg_write(`EP_CTRL_OFF, {7'h00, !tgl_exp, 24'h0});
    reg_read(`EP_CTRL_OFF, d);
    check(d[24], tgl_exp);
    reg_write(`EP_CTRL_OFF, 32'h0200_0000);
    reg_write(`EP_CTRL_OFF, {7'h01, !tgl_exp, 24'h0});
    tgl_exp = !tgl_exp;
    reg_read(`EP_CTRL_OFF, d);
    check(d[24], tgl_exp);
    check(tx_data_toggle, tgl_exp);
    host_mode <= 1'b0;
    reg_write(`EP_CTRL_OFF, {7'h01, !tgl_exp, 24'h0});
    reg_read(`EP_CTRL_OFF, d);
    check(d[24], tgl_exp);
    reg_write(`EP_CTRL_OFF, 32'h0);
  endtask

  task automatic t_auto();
    logic [7:0] c0;
    c0 = rx_cnt;
    ack_len <= 8'h04;
    reg_write(`EP_CTRL_OFF, 32'h8000_0004);
    push_words(3, 32'hA000_0000);
    wait_cycles(4);
    check(tx_packet_armed, 32'h0);
    check(rx_cnt, c0);
    push_words(1, 32'hA000_0003);
    for (int i = 0; i < 4 && tx_packet_armed !== 1'b1; i++) @(posedge clk);
    check(tx_packet_armed, 32'h1);
    wait_rx(c0 + 8'h04);
    check(rx_last, 32'hA000_0003);
    wait_cycles(3);
    tgl_exp = !tgl_exp;
    check(tx_packet_armed, 32'h0);
    check(tx_data_toggle, tgl_exp);
  endtask

  task automatic t_full();
    logic [7:0] c0;
    c0 = rx_cnt;
    ack_len <= 8'h08;
    stall <= 1'b1;
    reg_write(`EP_CTRL_OFF, 32'h0000_0004);
    push_words(8, 32'hB000_0000);
    wait_cycles(3);
    check(tx_in_ready, 32'h0);
    check(tx_packet_armed, 32'h0);
    reg_write(`EP_CTRL_OFF, 32'h0001_0004);
    wait_cycles(8);
    check(tx_out_valid, 32'h1);
    check(rx_cnt, c0);
    stall <= 1'b0;
    wait_rx(c0 + 8'h08);
    check(rx_last, 32'hB000_0007);
    wait_cycles(3);
    tgl_exp = !tgl_exp;
    check(tx_data_toggle, tgl_exp);
    check(tx_in_ready, 32'h1);
  endtask

  task automatic t_force();
    logic [7:0] c0;
    c0 = rx_cnt;
    push_words(2, 32'hC000_0000);
    reg_write(`EP_CTRL_OFF, 32'h0800_0004);
    wait_cycles(4);
    tgl_exp = !tgl_exp;
    check(tx_data_toggle, tgl_exp);
    check(tx_out_valid, 32'h0);
    reg_write(`EP_CTRL_OFF, 32'h0001_0004);
    wait_cycles(6);
    check(rx_cnt, c0);
    reg_write(`EP_CTRL_OFF, 32'h1401_0004);
    wait_cycles(3);
    check(dma_req, 32'h0);
    reg_write(`EP_CTRL_OFF, 32'h0400_0004);
    reg_write(`EP_CTRL_OFF, 32'h0000_0004);
  endtask

  task automatic t_timers();
    word_type d;
    int n;
    reg_write(`INFO_OFF, 32'h035C_0000);
    reg_write(`OTG_OFF, 32'h1);
    n = 0;
    repeat (30) begin
      @(posedge clk);
      if (vbus_charge === 1'b1) n++;
    end
    check(n >= 12 && n <= 13, 32'h1);
    conn_raw <= 1'b1;
    wait_cycles(100);
    check(conn_state, 32'h0);
    wait_cycles(20);
    check(conn_state, 32'h1);
    id_pin_level <= 1'b1;
    reg_write(`OTG_OFF, 32'h2);
    wait_cycles(60);
    check(id_pullup, 32'h1);
    check(id_valid, 32'h0);
    wait_cycles(20);
    check(id_valid, 32'h1);
    reg_read(`OTG_OFF, d);
    check(d[10:8], 32'h6);
    check(d[11], 32'h1);
    reg_write(`OTG_OFF, 32'h0);
    wait_cycles(3);
    check(id_valid, 32'h0);
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    check(tx_packet_armed, 32'h0);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_info();
    t_modes();
    t_dma();
    t_toggle();
    t_auto();
    t_full();
    t_force();
    t_timers();
    complete_run();
  end
endmodule // tb_usb_tx_ep
